// ===== rtl/scs_clock_ctrl.sv
`timescale 1ns/100ps
// Contract
// - single channel: its samples consecutively
// - two channels: lower first, alternate
// - four channels: order 0,2,1,3 each index; code does this only with fifo_mode set, else 0,1,2,3
// - sample encoding identical in both modes
// - default source: PLL from 40 MHz
// - read returns nearest achievable rate
// - clock output only with internal clocking
// - internal rate never below 1 kHz
// - maximum rate depends on variant, channels
// - quartz mode: quartz over listed divider
// - external reference 1 to 125 MHz
// - backplane mode locks to 10 MHz
// - direct external clock samples on connector
// - external clock divided to slower rate
module scs_clock_ctrl #(
    parameter logic [31:0] MAX_RATE_1CH = 32'd100_000_000,
    parameter logic [31:0] MAX_RATE_2CH = 32'd50_000_000
) (
    // clock and reset
    input  wire logic                                        clk,
    input  wire logic                                        rst,
    // register port
    input  wire logic [15:0]                                 reg_addr,
    input  wire logic [31:0]                                 reg_wdata,
    input  wire logic                                        reg_wr,
    input  wire logic                                        reg_rd,
    output logic      [31:0]                                 reg_rdata,
    output logic                                             reg_rvalid,
    // configuration
    input  wire logic [2:0]                                  clk_mode,
    input  wire logic                                        acq_run,
    input  wire logic [15:0]                                 ext_div,
    // clock pins
    input  wire logic                                        ext_clk_in,
    input  wire logic                                        bp_ref_in,
    output logic                                             clk_out_o,
    output logic                                             clk_out_oe,
    // acquisition side
    input  wire logic [scs_pkg::NCH-1:0][scs_pkg::SMP_W-1:0] adc_data,
    input  wire logic [scs_pkg::NCH-1:0]                     ch_en,
    input  wire logic                                        fifo_mode,
    output logic                                             sample_tick,
    output logic                                             pll_locked,
    output logic      [scs_pkg::SMP_W-1:0]                   fifo_word,
    output logic      [1:0]                                  fifo_ch,
    output logic                                             fifo_valid,
    output logic                                             overrun
);

    scs_pkg::scs_mode_t      mode_q;
    logic [31:0]             req_q;
    logic [31:0]             ach_q;
    logic                    cko_q;
    logic                    cko_q_oe_q;
    logic [31:0]             rdata_q;
    logic                    rvalid_q;
    logic [31:0]             acc_q;
    logic                    out_q;
    logic                    tick_q;
    logic [2:0]              ext_s_q;
    logic [2:0]              bp_s_q;
    logic [15:0]             div_q;
    logic [scs_pkg::LOCK_CNT_W-1:0] lock_cnt_q;
    logic                    lock_q;

    ////////////////////////////////////////////////////////////////////////////
    // nearest achievable rate
    function automatic logic [31:0] scs_achieve(input logic [31:0] req,
                                                input logic        quartz,
                                                input logic [31:0] max);
        logic [31:0] r;
        logic [31:0] best;
        logic [31:0] cand;
        logic [31:0] bd;
        logic [31:0] cd;
        r    = req;
        if (r < scs_pkg::MIN_RATE_HZ) begin
            r = scs_pkg::MIN_RATE_HZ;
        end
        if (r > max) begin
            r = max;
        end
        best = max;
        bd   = max - r;
        if (quartz) begin
            for (int i = 0; i < scs_pkg::QDIV_N; i++) begin
                cand = max / scs_pkg::QDIV[i];
                cd   = (cand > r) ? cand - r : r - cand;
                if (cd < bd) begin
                    bd   = cd;
                    best = cand;
                end
            end
            r = best;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire        multi_w   = (ch_en & (ch_en - 4'h1)) != 4'h0;
    wire [31:0] max_w     = multi_w ? MAX_RATE_2CH : MAX_RATE_1CH;
    wire        quartz_w  = mode_q == scs_pkg::SCS_QUARTZ;
    wire        nco_w     = mode_q == scs_pkg::SCS_INT_PLL || quartz_w ||
                            mode_q == scs_pkg::SCS_EXT_REF ||
                            mode_q == scs_pkg::SCS_BACKPLANE;
    wire        int_w     = mode_q == scs_pkg::SCS_INT_PLL || quartz_w ||
                            mode_q == scs_pkg::SCS_BACKPLANE;
    wire        ext_edge  = ext_s_q[1] && !ext_s_q[2];
    wire        bp_edge   = bp_s_q[1] && !bp_s_q[2];
    wire        ref_edge  = (mode_q == scs_pkg::SCS_BACKPLANE) ? bp_edge : ext_edge;
    wire        need_ref  = mode_q == scs_pkg::SCS_EXT_REF || mode_q == scs_pkg::SCS_BACKPLANE;
    wire [32:0] acc_sum   = {1'b0, acc_q} + {1'b0, ach_q};
    wire        acc_wrap  = acc_sum >= {1'b0, scs_pkg::CLK_HZ};
    wire [32:0] acc_nxt   = acc_wrap ? acc_sum - {1'b0, scs_pkg::CLK_HZ} : acc_sum;
    wire        div_done  = div_q + 16'h0001 >= ext_div;
    wire        mode_ok   = clk_mode <= 3'(scs_pkg::SCS_BACKPLANE);
    wire        tick_d    = (nco_w && acc_wrap && (lock_q || !need_ref)) ||
                            (mode_q == scs_pkg::SCS_EXT_DIRECT && ext_edge) ||
                            (mode_q == scs_pkg::SCS_EXT_DIV && ext_edge && div_done);
    wire        sel_rate  = reg_addr == scs_pkg::RATE_OFS;
    wire        sel_cko   = reg_addr == scs_pkg::CLKOUT_OFS;

    ////////////////////////////////////////////////////////////////////////////
    // registers and mode
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q   <= scs_pkg::SCS_INT_PLL;
            req_q    <= scs_pkg::RATE_RST;
            ach_q    <= scs_pkg::RATE_RST;
            cko_q    <= scs_pkg::CLKOUT_RST;
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            if (!acq_run && mode_ok) begin
                mode_q <= scs_pkg::scs_mode_t'(clk_mode);
            end
            if (reg_wr && sel_rate) begin
                req_q <= reg_wdata;
            end
            if (reg_wr && sel_cko) begin
                cko_q <= reg_wdata[scs_pkg::CLKOUT_BIT];
            end
            ach_q    <= scs_achieve(req_q, quartz_w, max_w);
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= sel_rate ? ach_q : (sel_cko ? {31'h0, cko_q} : 32'h0000_0000);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and lock monitor
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_s_q    <= 3'h0;
            bp_s_q     <= 3'h0;
            lock_cnt_q <= '0;
            lock_q     <= 1'b0;
        end else begin
            ext_s_q <= {ext_s_q[1:0], ext_clk_in};
            bp_s_q  <= {bp_s_q[1:0], bp_ref_in};
            if (!need_ref) begin
                lock_cnt_q <= '0;
                lock_q     <= 1'b1;
            end else if (ref_edge) begin
                lock_cnt_q <= '0;
                lock_q     <= 1'b1;
            end else if (lock_cnt_q == scs_pkg::LOCK_CNT_W'(scs_pkg::LOCK_WIN_CYC - 1)) begin
                lock_q <= 1'b0;
            end else begin
                lock_cnt_q <= lock_cnt_q + scs_pkg::LOCK_CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample clock generation
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q  <= 32'h0000_0000;
            out_q  <= 1'b0;
            tick_q <= 1'b0;
            div_q  <= 16'h0000;
        end else begin
            acc_q  <= nco_w ? acc_nxt[31:0] : 32'h0000_0000;
            out_q  <= cko_q && int_w && acc_q >= scs_pkg::CLK_HALF_HZ;
            tick_q <= tick_d;
            if (mode_q != scs_pkg::SCS_EXT_DIV) begin
                div_q <= 16'h0000;
            end else if (ext_edge) begin
                div_q <= div_done ? 16'h0000 : div_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample packing
    scs_smp_if smp ();

    assign smp.tick      = tick_q;
    assign smp.data      = adc_data;
    assign smp.en        = ch_en;
    assign smp.fifo_mode = fifo_mode;

    scs_packer u_packer (
        .clk (clk),
        .rst (rst),
        .smp (smp)
    );

    assign reg_rdata   = rdata_q;
    assign reg_rvalid  = rvalid_q;
    assign clk_out_o   = out_q;
    assign clk_out_oe  = cko_q_oe_q;
    assign sample_tick = tick_q;
    assign pll_locked  = lock_q;
    assign fifo_word   = smp.word;
    assign fifo_ch     = smp.word_ch;
    assign fifo_valid  = smp.word_valid;
    assign overrun     = smp.overrun;

    always_ff @(posedge clk) begin
        if (rst) begin
            cko_q_oe_q <= 1'b0;
        end else begin
            cko_q_oe_q <= cko_q && int_w;
        end
    end

endmodule

// ===== rtl/scs_pkg.sv
package scs_pkg;

    // register offsets
    localparam logic [15:0] RATE_OFS     = 16'h4E20;
    localparam logic [15:0] CLKOUT_OFS   = 16'h4E8E;
    localparam int          CLKOUT_BIT   = 0;

    // reset values
    localparam logic [31:0] RATE_RST     = 32'h000F_4240;
    localparam logic        CLKOUT_RST   = 1'b0;

    // frequencies in hertz
    localparam logic [31:0] CLK_HZ         = 32'd200_000_000;
    localparam logic [31:0] CLK_HALF_HZ    = CLK_HZ >> 1;
    localparam logic [31:0] INT_REF_HZ     = 32'd40_000_000;
    localparam logic [31:0] BP_REF_HZ      = 32'd10_000_000;
    localparam logic [31:0] EXT_REF_MIN_HZ = 32'd1_000_000;
    localparam logic [31:0] EXT_REF_MAX_HZ = 32'd125_000_000;
    localparam logic [31:0] MIN_RATE_HZ    = 32'd1_000;

    // reference must show an edge within this window to count as locked
    localparam int          CLK_PERIOD_PS  = 5000;
    localparam int          LOCK_WIN_NS    = 2000;
    localparam int          LOCK_WIN_CYC   = (LOCK_WIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
    localparam int          LOCK_CNT_W     = 10;

    // quartz divider list
    localparam int          QDIV_N = 17;
    localparam int unsigned QDIV [QDIV_N] = '{1, 2, 4, 8, 10, 16, 20, 40, 50, 80, 100,
                                             200, 400, 500, 800, 1000, 2000};

    // channel sample layout
    localparam int          NCH   = 4;
    localparam int          SMP_W = 16;

    // clock source modes
    typedef enum logic [2:0] {
        SCS_INT_PLL,
        SCS_QUARTZ,
        SCS_EXT_REF,
        SCS_EXT_DIRECT,
        SCS_EXT_DIV,
        SCS_BACKPLANE
    } scs_mode_t;

endpackage

// ===== rtl/scs_smp_if.sv
`timescale 1ns/100ps
interface scs_smp_if;
    logic                                          tick;
    logic [scs_pkg::NCH-1:0][scs_pkg::SMP_W-1:0]   data;
    logic [scs_pkg::NCH-1:0]                       en;
    logic                                          fifo_mode;
    logic [scs_pkg::SMP_W-1:0]                     word;
    logic [1:0]                                    word_ch;
    logic                                          word_valid;
    logic                                          overrun;

    modport src (output tick, data, en, fifo_mode, input word, word_ch, word_valid, overrun);
    modport pkr (input tick, data, en, fifo_mode, output word, word_ch, word_valid, overrun);
endinterface

// ===== rtl/scs_packer.sv
`timescale 1ns/100ps
module scs_packer (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // sample stream
    scs_smp_if.pkr    smp
);

    typedef logic [3:0][1:0] scs_ord_t;

    logic [scs_pkg::NCH-1:0][scs_pkg::SMP_W-1:0] hold_q;
    scs_ord_t                                    ord_q;
    logic [2:0]                                  cnt_q;
    logic [2:0]                                  idx_q;
    logic                                        busy_q;
    logic [scs_pkg::SMP_W-1:0]                   word_q;
    logic [1:0]                                  ch_q;
    logic                                        valid_q;
    logic                                        ovr_q;

    ////////////////////////////////////////////////////////////////////////////
    // emission order from the enabled set
    function automatic scs_ord_t scs_order(input logic [3:0] en, input logic fifo);
        scs_ord_t o;
        int       k;
        o = '0;
        k = 0;
        if (fifo && en == 4'hF) begin
            o = {2'd3, 2'd1, 2'd2, 2'd0};
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (en[c]) begin
                    o[k] = c[1:0];
                    k++;
                end
            end
        end
        return o;
    endfunction

    function automatic logic [2:0] scs_count(input logic [3:0] en);
        logic [2:0] n;
        n = 3'd0;
        for (int c = 0; c < 4; c++) begin
            n = n + {2'b00, en[c]};
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    wire        last_w  = busy_q && (idx_q + 3'd1 == cnt_q);
    wire        start_w = smp.tick && smp.en != 4'h0;
    wire [1:0]  cur_ch  = ord_q[idx_q[1:0]];

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_q  <= '0;
            ord_q   <= '0;
            cnt_q   <= 3'd0;
            idx_q   <= 3'd0;
            busy_q  <= 1'b0;
            word_q  <= '0;
            ch_q    <= 2'd0;
            valid_q <= 1'b0;
            ovr_q   <= 1'b0;
        end else begin
            valid_q <= busy_q;
            ovr_q   <= start_w && busy_q && !last_w;
            if (busy_q) begin
                word_q <= hold_q[cur_ch];
                ch_q   <= cur_ch;
                idx_q  <= idx_q + 3'd1;
            end
            if (start_w) begin
                hold_q <= smp.data;
                ord_q  <= scs_order(smp.en, smp.fifo_mode);
                cnt_q  <= scs_count(smp.en);
                idx_q  <= 3'd0;
                busy_q <= 1'b1;
            end else if (last_w) begin
                busy_q <= 1'b0;
            end
        end
    end

    assign smp.word       = word_q;
    assign smp.word_ch    = ch_q;
    assign smp.word_valid = valid_q;
    assign smp.overrun    = ovr_q;

endmodule

// ===== test/scs_clock_ctrl_assertions.sv
`timescale 1ns/100ps
module scs_clock_ctrl_checker (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     rst,
    // register port
    input wire logic                     reg_rd,
    input wire logic                     reg_rvalid,
    // configuration and pins
    input wire logic [2:0]               clk_mode,
    input wire logic                     acq_run,
    input wire logic                     ext_clk_in,
    input wire logic                     bp_ref_in,
    input wire logic                     clk_out_oe,
    // acquisition side
    input wire logic [scs_pkg::NCH-1:0]  ch_en,
    input wire logic                     fifo_mode,
    input wire logic                     sample_tick,
    input wire logic                     pll_locked,
    input wire logic [1:0]               fifo_ch,
    input wire logic                     fifo_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // cycles since the backplane reference last moved while in backplane mode
    logic       ref_q;
    logic [9:0] idle_q;
    wire        ref_edge = bp_ref_in != ref_q;
    wire  [1:0] lo_ch    = ch_en[0] ? 2'h0 : ch_en[1] ? 2'h1 : ch_en[2] ? 2'h2 : 2'h3;

    always_ff @(posedge clk) begin
        ref_q <= bp_ref_in;
        if (rst || ref_edge || acq_run || clk_mode != 3'h5)
            idle_q <= 10'h000;
        else if (idle_q != 10'h3FF)
            idle_q <= idle_q + 10'h001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_rd_answer;
        reg_rd |=> reg_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read strobe without answer next cycle");
    property p_oe_ext;
        (!acq_run && clk_mode inside {3'h2, 3'h3, 3'h4})[*3] |-> !clk_out_oe;
    endproperty
    a_oe_ext: assert property (p_oe_ext)
        else $error("clock output driven with external clocking");
    property p_tick_gap;
        sample_tick |=> !sample_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("sample ticks closer than the maximum rate");
    property p_pack_start;
        sample_tick && ch_en != 4'h0 |-> ##2 fifo_valid;
    endproperty
    a_pack_start: assert property (p_pack_start)
        else $error("no packed word two cycles after tick");
    property p_first_ch;
        $rose(fifo_valid) |-> fifo_ch == $past(lo_ch, 2);
    endproperty
    a_first_ch: assert property (p_first_ch)
        else $error("set does not start with lowest enabled channel");
    property p_order4;
        fifo_valid && fifo_ch == 2'h0 && fifo_mode && ch_en == 4'hF |=>
            fifo_valid && fifo_ch == 2'h2 ##1 fifo_valid && fifo_ch == 2'h1
            ##1 fifo_valid && fifo_ch == 2'h3;
    endproperty
    a_order4: assert property (p_order4)
        else $error("four channel order wrong");
    property p_lock_drop;
        idle_q >= 10'h1C2 |-> !pll_locked;
    endproperty
    a_lock_drop: assert property (p_lock_drop)
        else $error("lock held without backplane reference");
    property p_freeze;
        acq_run[*4] |-> $stable(clk_out_oe);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("clock source changed during acquisition");
    property p_ext_quiet;
        (!acq_run && clk_mode == 3'h3 && $stable(ext_clk_in))[*6] |-> !sample_tick;
    endproperty
    a_ext_quiet: assert property (p_ext_quiet)
        else $error("tick without connector clock edge");
endmodule

bind scs_clock_ctrl scs_clock_ctrl_checker u_chk (.clk(clk), .rst(rst), .reg_rd(reg_rd),
    .reg_rvalid(reg_rvalid), .clk_mode(clk_mode), .acq_run(acq_run), .ext_clk_in(ext_clk_in),
    .bp_ref_in(bp_ref_in), .clk_out_oe(clk_out_oe), .ch_en(ch_en), .fifo_mode(fifo_mode),
    .sample_tick(sample_tick), .pll_locked(pll_locked), .fifo_ch(fifo_ch),
    .fifo_valid(fifo_valid));

// ===== test/scs_host_model.sv
`timescale 1ns/100ps
module scs_host_model (
    // clock
    input wire logic  clk,
    // register port
    output logic [15:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic        reg_wr,
    output logic        reg_rd
);
    initial begin
        reg_addr  = 16'h0000;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // one-cycle strobe, released lines show the inverse of the last value
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        repeat (3) @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ===== test/tb_sample_clock_and_fifo_order.sv
`timescale 1ns/100ps
module tb_sample_clock_and_fifo_order;
    logic        clk, rst, reg_wr, reg_rd, reg_rvalid, acq_run, ext_clk_in, bp_ref_in;
    logic        clk_out_o, clk_out_oe, fifo_mode, sample_tick, pll_locked, fifo_valid, overrun;
    logic [15:0] reg_addr, ext_div, fifo_word;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0]  clk_mode;
    logic [1:0]  fifo_ch;
    logic [3:0]  ch_en;
    logic [scs_pkg::NCH-1:0][scs_pkg::SMP_W-1:0] adc_data;
    logic [31:0] rd_q[$];
    logic [17:0] fifo_q[$];
    int          failures, cmp_count, ticks, cyc, hp, pc, age, k, hi, ovr;
    localparam int          ORD [4] = '{0, 2, 1, 3};
    localparam logic [31:0] REQ [6] = '{32'h004C_4B40, 32'h0000_01F4, 32'h04C4_B400,
                                        32'h08F0_D180, 32'h01C9_C380, 32'h002D_C6C0};
    localparam logic [31:0] EXP [6] = '{32'h004C_4B40, 32'h0000_03E8, 32'h02FA_F080,
                                        32'h05F5_E100, 32'h017D_7840, 32'h0026_25A0};
    localparam logic [3:0]  CH  [6] = '{4'h0, 4'h0, 4'h3, 4'h0, 4'h0, 4'h0};
    localparam logic [2:0]  MD  [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1};
    localparam logic [3:0]  PAT [6] = '{4'h1, 4'h4, 4'h5, 4'h3, 4'hF, 4'hF};
    localparam logic        FM  [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

    scs_clock_ctrl dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .clk_mode(clk_mode), .acq_run(acq_run), .ext_div(ext_div), .ext_clk_in(ext_clk_in),
        .bp_ref_in(bp_ref_in), .clk_out_o(clk_out_o), .clk_out_oe(clk_out_oe),
        .adc_data(adc_data), .ch_en(ch_en), .fifo_mode(fifo_mode), .sample_tick(sample_tick),
        .pll_locked(pll_locked), .fifo_word(fifo_word), .fifo_ch(fifo_ch),
        .fifo_valid(fifo_valid), .overrun(overrun));
    scs_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        host.rd(a);
    endtask
    task automatic count_ticks(input int n);
        ticks = 0;
        hi = 0;
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_tick();
        int n;
        n = 0;
        while (sample_tick !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk(n < 1000, 1'b1);
        repeat (20) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // stimulus clock on the connector and backplane pins, held still when hp is zero
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            stop_test();
        end
        if (sample_tick === 1'b1)
            ticks++;
        if (clk_out_o === 1'b1)
            hi++;
        if (overrun === 1'b1)
            ovr++;
        if (hp != 0 && pc >= hp - 1) begin
            pc <= 0;
            ext_clk_in <= ~ext_clk_in;
            bp_ref_in  <= ~bp_ref_in;
        end else if (hp != 0)
            pc <= pc + 1;
        // the sample driver notes each set as it is taken
        if (sample_tick === 1'b1 && ch_en != 4'h0) begin
            for (int i = 0; i < 4; i++) begin
                k = (fifo_mode && ch_en == 4'hF) ? ORD[i] : i;
                if (ch_en[k])
                    fifo_q.push_back({k[1:0], adc_data[k]});
            end
        end
        age <= (sample_tick === 1'b1) ? 0 : age + 1;
        if (age == 50)
            adc_data <= {$urandom, $urandom};
    end
    always @(posedge clk) begin
        if (reg_rvalid === 1'b1)
            chk(reg_rdata, rd_q.size() != 0 ? rd_q.pop_front() : 32'hxxxx_xxxx);
        if (fifo_valid === 1'b1)
            chk({14'h0000, fifo_ch, fifo_word}, fifo_q.size() != 0 ?
                {14'h0000, fifo_q.pop_front()} : 32'hxxxx_xxxx);
    end

    initial begin
        rst = 1'b1;
        clk_mode = 3'h0;
        acq_run = 1'b0;
        ext_div = 16'h0004;
        adc_data = '0;
        ch_en = 4'h0;
        fifo_mode = 1'b0;
        ext_clk_in = 1'b0;
        bp_ref_in = 1'b0;
        void'($urandom(32'h1e8f));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(scs_pkg::RATE_OFS, scs_pkg::RATE_RST);
        rd(scs_pkg::CLKOUT_OFS, 32'h0000_0000);
        rd(16'h0004, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            clk_mode <= MD[i];
            ch_en    <= CH[i];
            host.wr(scs_pkg::RATE_OFS, REQ[i]);
            rd(scs_pkg::RATE_OFS, EXP[i]);
        end
        clk_mode <= 3'h0;
        ch_en <= 4'h1;
        host.wr(scs_pkg::RATE_OFS, 32'h004C_4B40);
        host.wr(scs_pkg::CLKOUT_OFS, 32'hFFFF_FFFF);
        rd(scs_pkg::CLKOUT_OFS, 32'h0000_0001);
        count_ticks(2000);
        chk(ticks >= 49 && ticks <= 51, 1'b1);
        chk(hi >= 990 && hi <= 1010, 1'b1);
        chk(clk_out_oe, 1'b1);
        acq_run <= 1'b1;
        clk_mode <= 3'h2;
        repeat (20) @(posedge clk);
        chk(clk_out_oe, 1'b1);
        acq_run <= 1'b0;
        hp <= 10;
        repeat (400) @(posedge clk);
        chk(clk_out_oe, 1'b0);
        chk(pll_locked, 1'b1);
        count_ticks(2000);
        chk(ticks >= 49 && ticks <= 51, 1'b1);
        chk(hi, 32'h0000_0000);
        clk_mode <= 3'h5;
        repeat (400) @(posedge clk);
        chk(pll_locked, 1'b1);
        hp <= 0;
        repeat (500) @(posedge clk);
        chk(pll_locked, 1'b0);
        count_ticks(400);
        chk(ticks, 32'h0000_0000);
        ch_en <= 4'hF;
        fifo_mode <= 1'b1;
        clk_mode <= 3'h3;
        hp <= 4;
        repeat (20) @(posedge clk);
        count_ticks(800);
        chk(ticks >= 99 && ticks <= 101, 1'b1);
        hp <= 0;
        repeat (8) @(posedge clk);
        count_ticks(40);
        chk(ticks, 32'h0000_0000);
        hp <= 4;
        clk_mode <= 3'h4;
        repeat (40) @(posedge clk);
        count_ticks(800);
        chk(ticks >= 24 && ticks <= 26, 1'b1);
        hp <= 0;
        clk_mode <= 3'h0;
        host.wr(scs_pkg::RATE_OFS, 32'h000F_4240);
        for (int i = 0; i < 6; i++) begin
            wait_tick();
            ch_en     <= PAT[i];
            fifo_mode <= FM[i];
            repeat (430) @(posedge clk);
        end
        repeat (10) @(posedge clk);
        chk(fifo_q.size(), 32'h0000_0000);
        chk(rd_q.size(), 32'h0000_0000);
        chk(ovr, 32'h0000_0000);
        stop_test();
    end
endmodule
